// File: hdl/tmrevt_ctrl.sv
// Purpose: Event action, interrupt flags, debug run and 16-bit access for a timer.
// Assumes: Counter, period and compare datapaths sit outside and use the step outputs.
// Notes:   Register reads answer one cycle after the read strobe.
`timescale 1ns/1ps

module tmrevt_ctrl
  import tmrevt_pkg::*;
#(
  parameter int NCH = 3
)
(
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 event_a_in,
  input  wire logic                 prescale_tick,
  input  wire logic                 cpu_halted,
  input  wire logic                 top_reached,
  input  wire logic                 bottom_reached,
  input  wire logic                 wrap_on_top,
  input  wire logic                 wrap_on_bottom,
  input  wire logic [15:0]          counter_value,
  input  wire logic [NCH-1:0][15:0] compare_value,
  output logic                      count_step,
  output logic                      count_down,
  output logic                      direction_from_event,
  output logic                      timer_running,
  output logic                      wide_wr_strobe,
  output logic      [1:0]           wide_wr_sel,
  output logic      [15:0]          wide_wr_data,
  output logic                      irq_req_wrap,
  output logic      [NCH-1:0]       irq_req_cmp
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  evcfg_q;
  logic [7:0]  inten_q;
  logic [7:0]  intflg_q;
  logic [7:0]  intflg_d;
  logic [7:0]  brkcfg_q;
  logic [7:0]  temp_q;
  logic [7:0]  temp_d;
  logic [7:0]  rdata_q;
  logic        step_q;
  logic        step_d;
  logic        down_q;
  logic        wstrb_q;
  logic [1:0]  wsel_q;
  logic [15:0] wdata_q;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire hit_evcfg   = (reg_addr == TMREVT_EVCFG_OFS);
  wire hit_inten   = (reg_addr == TMREVT_INTEN_OFS);
  wire hit_intflg  = (reg_addr == TMREVT_INTFLG_OFS);
  wire hit_brkcfg  = (reg_addr == TMREVT_BRKCFG_OFS);
  wire hit_temp    = (reg_addr == TMREVT_TEMP_OFS);

  // Wide registers occupy byte pairs: even address low, odd address high
  logic        wide_hit;
  logic [1:0]  wide_sel;
  logic [15:0] wide_val;

  always_comb
  begin
    wide_hit = 1'b0;
    wide_sel = 2'd0;
    wide_val = 16'h0000;
    if (reg_addr[7:1] == TMREVT_CNT_OFS[7:1])
    begin
      wide_hit = 1'b1;
      wide_sel = 2'd0;
      wide_val = counter_value;
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (reg_addr[7:1] == 7'(TMREVT_CMP_BASE_OFS[7:1] + i * TMREVT_CMP_STRIDE[7:1]))
      begin
        wide_hit = 1'b1;
        wide_sel = 2'(i + 1);
        wide_val = compare_value[i];
      end
    end
  end

  wire wide_lo = wide_hit & ~reg_addr[0];
  wire wide_hi = wide_hit & reg_addr[0];

  wire wr_evcfg   = reg_wr_en & hit_evcfg;
  wire wr_inten   = reg_wr_en & hit_inten;
  wire wr_intflg  = reg_wr_en & hit_intflg;
  wire wr_brkcfg  = reg_wr_en & hit_brkcfg;
  wire wr_temp    = reg_wr_en & hit_temp;
  wire wr_wide_lo = reg_wr_en & wide_lo;
  wire wr_wide_hi = reg_wr_en & wide_hi;
  wire rd_wide_lo = reg_rd_en & wide_lo;

  // ----------------------------------------------------------------------
  // Event input and debug gating
  // ----------------------------------------------------------------------
  logic ev_level;
  logic ev_rise;
  logic ev_fall;

  tmrevt_edge u_edge_a
  (
    .core_clk (core_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .async_in (event_a_in),
    .level    (ev_level),
    .rise     (ev_rise),
    .fall     (ev_fall)
  );

  wire       eva_en  = evcfg_q[TMREVT_EVA_EN_BIT];
  wire [2:0] eva_act = evcfg_q[TMREVT_EVA_ACT_LSB +: 3];
  wire       dbg_run = brkcfg_q[TMREVT_BRKRUN_BIT];

  // Edges seen during a break are dropped, not replayed afterwards
  wire run_ok  = ~cpu_halted | dbg_run;                     // [R14] [R15]
  wire mode_ud = eva_en & (eva_act == TMREVT_ACT_DIRECTION_FROM_EVENT);

  // Reserved action codes leave the counter on plain prescaled ticks
  always_comb
  begin
    step_d = 1'b0;
    if (!eva_en)
      step_d = prescale_tick;                               // [R6]
    else
    begin
      unique case (eva_act)                                 // [R7]
        TMREVT_ACT_RISE:   step_d = ev_rise;                // [R1]
        TMREVT_ACT_ANY:    step_d = ev_rise | ev_fall;      // [R2]
        TMREVT_ACT_HIGH:   step_d = prescale_tick & ev_level; // [R3]
        TMREVT_ACT_DIRECTION_FROM_EVENT: step_d = prescale_tick;          // [R4]
        default:           step_d = prescale_tick;
      endcase
    end
    if (!run_ok)
      step_d = 1'b0;                                        // [R14]
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      step_q <= 1'b0;
      down_q <= 1'b0;
    end
    else if (clk_en)
    begin
      step_q <= step_d;
      if (step_d && mode_ud)
        down_q <= ev_level;                                 // [R4] [R5]
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------------
  logic [NCH-1:0] cmp_match;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      cmp_match[i] = (counter_value == compare_value[i]);   // [R18]
  end

  wire wrap_hit = (top_reached & wrap_on_top) | (bottom_reached & wrap_on_bottom); // [R12]

  logic [7:0] flg_set;
  logic [7:0] flg_clr;

  always_comb
  begin
    flg_set = 8'h00;
    flg_set[TMREVT_WRAP_BIT] = wrap_hit;
    flg_set[TMREVT_CMP_BIT_LSB +: NCH] = cmp_match;         // [R10]
    flg_clr = wr_intflg ? reg_wdata : 8'h00;                // [R11] [R13] [R20]
    // Hardware set wins over a clear arriving in the same cycle
    intflg_d = ((intflg_q & ~flg_clr) | flg_set) & TMREVT_INT_MASK;
  end

  // ----------------------------------------------------------------------
  // Shared temporary byte
  // ----------------------------------------------------------------------
  always_comb
  begin
    temp_d = temp_q;
    if (wr_temp || wr_wide_lo)
      temp_d = reg_wdata;                                   // [R17] [R19]
    else if (rd_wide_lo)
      temp_d = wide_val[15:8];                              // [R16] [R19]
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_evcfg)
      rd_mux = evcfg_q;
    else if (hit_inten)
      rd_mux = inten_q & TMREVT_INT_MASK;                   // [R20]
    else if (hit_intflg)
      rd_mux = intflg_q & TMREVT_INT_MASK;                  // [R20]
    else if (hit_brkcfg)
      rd_mux = brkcfg_q & TMREVT_BRKCFG_MASK;
    else if (hit_temp)
      rd_mux = temp_q;                                      // [R17]
    else if (wide_lo)
      rd_mux = wide_val[7:0];
    else if (wide_hi)
      rd_mux = temp_q;                                      // [R19]
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      evcfg_q   <= TMREVT_EVCFG_RST;
      inten_q   <= TMREVT_INTEN_RST;
      intflg_q  <= TMREVT_INTFLG_RST;
      brkcfg_q  <= TMREVT_BRKCFG_RST;
      temp_q    <= TMREVT_TEMP_RST;
      rdata_q   <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_evcfg)
        evcfg_q <= reg_wdata;
      if (wr_inten)
        inten_q <= reg_wdata & TMREVT_INT_MASK;
      if (wr_brkcfg)
        brkcfg_q <= reg_wdata & TMREVT_BRKCFG_MASK;
      intflg_q <= intflg_d;
      temp_q   <= temp_d;
      if (reg_rd_en)
        rdata_q <= rd_mux;
    end
  end

  // High-byte write commits the pair so the datapath never sees half a value
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wstrb_q <= 1'b0;
      wsel_q  <= 2'd0;
      wdata_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      wstrb_q <= wr_wide_hi;                                // [R19]
      if (wr_wide_hi)
      begin
        wsel_q  <= wide_sel;
        wdata_q <= {reg_wdata, temp_q};                     // [R16] [R19]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata            = rdata_q;
  assign count_step           = step_q;
  assign count_down           = down_q;
  assign direction_from_event = mode_ud;
  assign timer_running        = run_ok;                     // [R14] [R15]
  assign wide_wr_strobe       = wstrb_q;
  assign wide_wr_sel          = wsel_q;
  assign wide_wr_data         = wdata_q;
  assign irq_req_wrap = inten_q[TMREVT_WRAP_BIT] & intflg_q[TMREVT_WRAP_BIT]; // [R9]
  assign irq_req_cmp  = inten_q[TMREVT_CMP_BIT_LSB +: NCH]
                      & intflg_q[TMREVT_CMP_BIT_LSB +: NCH];                 // [R8]

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  wire live = clk_en & run_ok;

  rise_step_a: assert property (clk_en && eva_en && eva_act == TMREVT_ACT_RISE && live // [R1]
    |=> count_step == $past(ev_rise))
    else $error("rising edge mode step mismatch");

  any_step_a: assert property (clk_en && eva_en && eva_act == TMREVT_ACT_ANY && live // [R2]
    |=> count_step == $past(ev_rise | ev_fall))
    else $error("any edge mode step mismatch");

  high_step_a: assert property (clk_en && eva_en && eva_act == TMREVT_ACT_HIGH && live // [R3]
    && prescale_tick |=> count_step == $past(ev_level))
    else $error("high level mode step mismatch");

  direction_from_event_dir_a: assert property (clk_en && mode_ud && live && prescale_tick // [R4] [R5]
    |=> count_step && count_down == $past(ev_level))
    else $error("direction not latched at step");

  dir_hold_a: assert property (clk_en && !step_d |=> $stable(count_down)) // [R5]
    else $error("direction changed without a step");

  disabled_ign_a: assert property (clk_en && !eva_en && run_ok // [R6] [R7]
    |=> count_step == $past(prescale_tick))
    else $error("disabled event input affected counting");

  break_halt_a: assert property (clk_en && cpu_halted && !dbg_run // [R14]
    |-> !timer_running ##1 !count_step)
    else $error("timer ran during break");

  break_run_a: assert property (cpu_halted && dbg_run |-> timer_running) // [R15]
    else $error("timer halted despite run in debug");

  cmp_set_a: assert property (clk_en && cmp_match[0] // [R10] [R18]
    |=> intflg_q[TMREVT_CMP_BIT_LSB])
    else $error("compare flag not set on match");

  cmp_sticky_a: assert property (intflg_q[TMREVT_CMP_BIT_LSB + 1] // [R11] [R20]
    && !(clk_en && wr_intflg && reg_wdata[TMREVT_CMP_BIT_LSB + 1])
    |=> intflg_q[TMREVT_CMP_BIT_LSB + 1])
    else $error("compare flag cleared without a one write");

  wrap_set_a: assert property (clk_en && bottom_reached && wrap_on_bottom // [R12]
    |=> intflg_q[TMREVT_WRAP_BIT])
    else $error("wrap flag not set");

  wrap_clear_a: assert property (clk_en && wr_intflg && reg_wdata[TMREVT_WRAP_BIT] // [R13]
    && !wrap_hit |=> !intflg_q[TMREVT_WRAP_BIT])
    else $error("wrap flag not cleared by one write");

  wrap_irq_a: assert property (clk_en && wr_inten && reg_wdata[TMREVT_WRAP_BIT] // [R9]
    && intflg_q[TMREVT_WRAP_BIT] |=> irq_req_wrap)
    else $error("wrap request not raised");

  cmp_irq_a: assert property (clk_en && wr_inten && reg_wdata[6:4] == 3'h0 // [R8]
    |=> irq_req_cmp == 3'h0)
    else $error("compare request without enable");

  temp_rw_a: assert property (clk_en && wr_temp |=> temp_q == $past(reg_wdata)) // [R17]
    else $error("temporary byte write wrong");

  wide_rd_a: assert property (clk_en && rd_wide_lo && !reg_wr_en // [R19] [R16]
    |=> temp_q == $past(wide_val[15:8]) && reg_rdata == $past(wide_val[7:0]))
    else $error("low byte read did not capture high byte");

  wide_wr_a: assert property (clk_en && wr_wide_hi // [R19]
    |=> wide_wr_strobe && wide_wr_data == {$past(reg_wdata), $past(temp_q)})
    else $error("high byte write did not commit pair");

  cv_direction_from_event_c: cover property (mode_ud && count_step ##1 count_step && count_down);
  cv_break_c:  cover property (cpu_halted && !dbg_run ##1 cpu_halted && dbg_run);
  cv_wide_c:   cover property (wr_wide_lo ##[1:4] wide_wr_strobe);
  cv_irq_c:    cover property (irq_req_wrap && irq_req_cmp[2]);

endmodule

// File: hdl/tmrevt_edge.sv
// Purpose: Synchronise an event channel and report its level and edges.
// Assumes: Event line may come from another clock domain.
// Notes:   Edges are one-cycle pulses aligned with the synchronised level.
`timescale 1ns/1ps

module tmrevt_edge
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule

// File: include/tmrevt_pkg.sv
// Purpose: Constants shared by the timer event, interrupt and debug control slice.
// Assumes: Byte-wide CPU register bus, one peripheral clock, synchronous reset.
// Notes:   Offsets are byte addresses on the peripheral register bus.
//
// How it works
// [R1] Enabled input A, code 0x0: one count step per rising event edge.
// [R2] Enabled input A, code 0x1: one count step per rising and falling edge.
// [R3] Code 0x2: prescaled ticks counted only while the event is high.
// [R4] Code 0x3: prescaled ticks counted, up while event low, down while high.
// [R5] In direction mode the event level is latched when a step is taken.
// [R6] Input A disabled: the event has no effect whatever the action code.
// [R7] Input A enabled: the event acts as the three-bit action field selects.
// [R8] Compare channels 0..2 have interrupt enables at bits 4, 5 and 6.
// [R9] Enable bit 0 gates the wrap request; request needs enable and flag.
// [R10] A compare flag sets whenever counter value equals its compare value.
// [R11] Compare flags stay set until software writes one to the bit.
// [R12] Wrap flag bit 0 sets at TOP or BOTTOM as the waveform mode selects.
// [R13] Wrap flag stays set until software writes one to its bit.
// [R14] Run-in-debug at 0: timer stops and ignores events during a break.
// [R15] Run-in-debug at 1: timer runs normally during a debug break.
// [R16] One shared temporary byte serves every 16-bit register of the timer; only the counter and compare registers are decoded here.
// [R17] The temporary byte is directly readable and writable, reset value zero.
// [R18] Compare values are compared continuously with the counter value.
// [R19] Low byte read copies high byte to temp; high write commits both bytes.
// [R20] Writing zero leaves a flag unchanged; unused interrupt bits read zero.

package tmrevt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TMREVT_EVCFG_OFS    = 8'h09;
  localparam logic [7:0] TMREVT_INTEN_OFS    = 8'h0A;
  localparam logic [7:0] TMREVT_INTFLG_OFS   = 8'h0B;
  localparam logic [7:0] TMREVT_BRKCFG_OFS   = 8'h0E;
  localparam logic [7:0] TMREVT_TEMP_OFS     = 8'h0F;
  localparam logic [7:0] TMREVT_CNT_OFS      = 8'h20;
  localparam logic [7:0] TMREVT_CMP_BASE_OFS = 8'h28;
  localparam logic [7:0] TMREVT_CMP_STRIDE   = 8'h02;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TMREVT_EVA_EN_BIT   = 0;
  localparam int TMREVT_EVA_ACT_LSB  = 1;
  localparam int TMREVT_WRAP_BIT     = 0;
  localparam int TMREVT_CMP_BIT_LSB  = 4;
  localparam int TMREVT_BRKRUN_BIT   = 0;

  localparam logic [7:0] TMREVT_INT_MASK    = 8'h71;
  localparam logic [7:0] TMREVT_BRKCFG_MASK = 8'h01;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] TMREVT_EVCFG_RST   = 8'h00;
  localparam logic [7:0] TMREVT_INTEN_RST   = 8'h00;
  localparam logic [7:0] TMREVT_INTFLG_RST  = 8'h00;
  localparam logic [7:0] TMREVT_BRKCFG_RST  = 8'h00;
  localparam logic [7:0] TMREVT_TEMP_RST    = 8'h00;

  // ----------------------------------------------------------------------
  // Event A action codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] TMREVT_ACT_RISE   = 3'h0;
  localparam logic [2:0] TMREVT_ACT_ANY    = 3'h1;
  localparam logic [2:0] TMREVT_ACT_HIGH   = 3'h2;
  localparam logic [2:0] TMREVT_ACT_DIRECTION_FROM_EVENT = 3'h3;

endpackage

// File: verif/tb_tmrevt_ctrl.sv
// Purpose: Self-checking bench for the timer event, flag, debug and wide access slice.
// Assumes: Read data settles at the read edge and holds; clk_en stays high.
// Notes:   Reads queue their expected byte; a watcher pops and compares it.
`timescale 1ns/1ps

module tb_tmrevt_ctrl import tmrevt_pkg::*;;
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              clk_en = 1'b1;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr_en = 1'b0;
  logic              reg_rd_en = 1'b0;
  logic              ev_req = 1'b0;
  logic              tick_en = 1'b0;
  logic              cpu_halted = 1'b0;
  logic              top_reached = 1'b0;
  logic              bottom_reached = 1'b0;
  logic              wrap_on_top = 1'b0;
  logic              wrap_on_bottom = 1'b0;
  logic [15:0]       counter_value = 16'h0000;
  logic [2:0][15:0]  compare_value = {16'h0300, 16'h0200, 16'h0100};
  logic [7:0]        reg_rdata;
  logic              event_a_in, prescale_tick, count_step, count_down;
  logic              direction_from_event, timer_running, wide_wr_strobe;
  logic [1:0]        wide_wr_sel, stb_sel;
  logic [15:0]       wide_wr_data, stb_data, rv;
  logic              irq_req_wrap;
  logic [2:0]        irq_req_cmp;
  logic [7:0]        exp_q[$];
  logic [7:0]        ofs[6] = '{8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h30};
  int                mismatches = 0, n_checks = 0, n_steps = 0, n_stb = 0, cyc = 0;

  always #4 core_clk = ~core_clk;

  tmrevt_ctrl #(.NCH(3)) tmrevt_ctrl_inst (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .event_a_in(event_a_in), .prescale_tick(prescale_tick),
    .cpu_halted(cpu_halted), .top_reached(top_reached), .bottom_reached(bottom_reached),
    .wrap_on_top(wrap_on_top), .wrap_on_bottom(wrap_on_bottom), .counter_value(counter_value),
    .compare_value(compare_value), .count_step(count_step), .count_down(count_down),
    .direction_from_event(direction_from_event), .timer_running(timer_running),
    .wide_wr_strobe(wide_wr_strobe), .wide_wr_sel(wide_wr_sel), .wide_wr_data(wide_wr_data),
    .irq_req_wrap(irq_req_wrap), .irq_req_cmp(irq_req_cmp));

  tmrevt_far_model tmrevt_far_model_inst (.core_clk(core_clk), .srst(srst), .ev_req(ev_req),
    .tick_en(tick_en), .event_a_in(event_a_in), .prescale_tick(prescale_tick));

  // ----------------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp=%h got=%h", what, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    chk("reg_rdata", {8'h00, exp}, {8'h00, got});
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watcher: steps, wide strobes, read data, hang limit
  // ----------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cyc++;
    if (count_step === 1'b1)
      n_steps++;
    if (wide_wr_strobe === 1'b1)
    begin
      n_stb++;
      stb_sel = wide_wr_sel;
      stb_data = wide_wr_data;
    end
    if (cyc == 5000)
    begin
      mismatches++;
      test_done();
    end
    if (reg_rd_en === 1'b1)
    begin
      @(negedge core_clk);
      chk_rd(exp_q.pop_front(), reg_rdata);
    end
  end

  // ----------------------------------------------------------------------
  // Bus and event drivers
  // ----------------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    exp_q.push_back(exp);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(negedge core_clk);
  endtask

  // Settle time covers the two-stage synchroniser plus the step flop
  task automatic ev_check(input string what, input logic [7:0] ctl, input int pulses,
                          input int ticks, input int exp);
    bus_wr(TMREVT_EVCFG_OFS, ctl);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    n_steps = 0;
    @(posedge core_clk);
    repeat (pulses)
    begin
      ev_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      ev_req <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    if (ticks > 0)
    begin
      tick_en <= 1'b1;
      repeat (4 * ticks) @(posedge core_clk);
      tick_en <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk(what, 16'(exp), 16'(n_steps));
    $display("test %s done", what);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h77F7));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    foreach (ofs[i]) bus_rd(ofs[i], 8'h00);
    rv = 16'($urandom);
    bus_wr(TMREVT_TEMP_OFS, rv[7:0]);
    bus_rd(TMREVT_TEMP_OFS, rv[7:0]);
    bus_wr(TMREVT_INTEN_OFS, 8'hFF);
    bus_rd(TMREVT_INTEN_OFS, 8'h71);
    bus_wr(TMREVT_BRKCFG_OFS, 8'hFF);
    bus_rd(TMREVT_BRKCFG_OFS, 8'h01);
    bus_wr(TMREVT_BRKCFG_OFS, 8'h00);
    bus_wr(8'h30, 8'h5A);
    bus_rd(8'h30, 8'h00);
    $display("test registers done");
    @(posedge core_clk);
    counter_value <= 16'h0200;
    @(posedge core_clk);
    counter_value <= 16'h0000;
    repeat (2) @(negedge core_clk);
    chk("irq_req_cmp", 16'h0002, {13'h0, irq_req_cmp});
    bus_wr(TMREVT_INTFLG_OFS, 8'h00);
    bus_rd(TMREVT_INTFLG_OFS, 8'h20);
    bus_wr(TMREVT_INTFLG_OFS, 8'h20);
    bus_rd(TMREVT_INTFLG_OFS, 8'h00);
    @(posedge core_clk);
    bottom_reached <= 1'b1;
    @(posedge core_clk);
    bottom_reached <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("irq_req_wrap", 16'h0, {15'h0, irq_req_wrap});
    @(posedge core_clk);
    top_reached <= 1'b1;
    wrap_on_top <= 1'b1;
    @(posedge core_clk);
    top_reached <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("irq_req_wrap", 16'h1, {15'h0, irq_req_wrap});
    bus_rd(TMREVT_INTFLG_OFS, 8'h01);
    bus_wr(TMREVT_INTEN_OFS, 8'h70);
    @(negedge core_clk);
    chk("irq_req_wrap", 16'h0, {15'h0, irq_req_wrap});
    bus_wr(TMREVT_INTFLG_OFS, 8'h01);
    bus_rd(TMREVT_INTFLG_OFS, 8'h00);
    @(posedge core_clk);
    bottom_reached <= 1'b1;
    {wrap_on_top, wrap_on_bottom} <= 2'b01;
    @(posedge core_clk);
    bottom_reached <= 1'b0;
    bus_rd(TMREVT_INTFLG_OFS, 8'h01);
    $display("test flags done");
    rv = 16'h8000 | 16'($urandom);
    @(posedge core_clk);
    counter_value <= rv;
    bus_rd(TMREVT_CNT_OFS, rv[7:0]);
    @(posedge core_clk);
    counter_value <= 16'h0000;
    bus_rd(TMREVT_CNT_OFS + 8'h01, rv[15:8]);
    bus_rd(TMREVT_TEMP_OFS, rv[15:8]);
    bus_wr(TMREVT_CMP_BASE_OFS + 8'h04, rv[7:0]);
    bus_wr(TMREVT_CMP_BASE_OFS + 8'h05, rv[15:8]);
    repeat (2) @(negedge core_clk);
    chk("wide_wr_count", 16'h0001, 16'(n_stb));
    chk("wide_wr_sel", 16'h0003, {14'h0, stb_sel});
    chk("wide_wr_data", rv, stb_data);
    $display("test wide_access done");
    ev_check("steps_rise", {4'h0, TMREVT_ACT_RISE, 1'b1}, 3, 0, 3);
    ev_check("steps_any", {4'h0, TMREVT_ACT_ANY, 1'b1}, 3, 0, 6);
    ev_check("steps_off", {4'h0, TMREVT_ACT_ANY, 1'b0}, 3, 0, 0);
    ev_check("steps_reserved", {4'h0, 3'h5, 1'b1}, 0, 4, 4);
    @(posedge core_clk);
    ev_req <= 1'b1;
    ev_check("steps_high", {4'h0, TMREVT_ACT_HIGH, 1'b1}, 0, 5, 5);
    ev_check("steps_direction_from_event_hi", {4'h0, TMREVT_ACT_DIRECTION_FROM_EVENT, 1'b1}, 0, 3, 3);
    chk("count_down", 16'h1, {15'h0, count_down});
    chk("direction_from_event", 16'h1, {15'h0, direction_from_event});
    @(posedge core_clk);
    ev_req <= 1'b0;
    ev_check("steps_direction_from_event_lo", {4'h0, TMREVT_ACT_DIRECTION_FROM_EVENT, 1'b1}, 0, 3, 3);
    chk("count_down", 16'h0, {15'h0, count_down});
    ev_check("steps_low", {4'h0, TMREVT_ACT_HIGH, 1'b1}, 0, 5, 0);
    @(posedge core_clk);
    cpu_halted <= 1'b1;
    ev_check("steps_break", {4'h0, TMREVT_ACT_RISE, 1'b1}, 3, 0, 0);
    chk("timer_running", 16'h0, {15'h0, timer_running});
    bus_wr(TMREVT_BRKCFG_OFS, 8'h01);
    ev_check("steps_break_run", {4'h0, TMREVT_ACT_RISE, 1'b1}, 3, 0, 3);
    chk("timer_running", 16'h1, {15'h0, timer_running});
    test_done();
  end
endmodule

// File: verif/tmrevt_far_model.sv
// Purpose: Far-side model: event channel A source and prescaled tick source.
// Assumes: The bench requests event levels and tick bursts at core_clk rising edges.
// Notes:   Event edges land at a varying offset, as a channel from another domain would.
`timescale 1ns/1ps

module tmrevt_far_model
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ev_req,
  input  wire logic tick_en,
  output logic      event_a_in,
  output logic      prescale_tick
);
  logic [1:0]  div_q;
  int unsigned dly;

  // ----------------------------------------------------------------------
  // Event line
  // ----------------------------------------------------------------------
  // Skew against the clock so the synchroniser sees no fixed phase
  initial event_a_in = 1'b0;
  always @(ev_req)
  begin
    dly = 1 + ($urandom % 6);
    event_a_in <= #(dly) ev_req;
  end

  // ----------------------------------------------------------------------
  // Prescaled tick, one in four cycles
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst || !tick_en)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  assign prescale_tick = tick_en && (div_q == 2'h3);
endmodule
